// *** timer_cfg.svh ***
// Constants of the dual timer: register offsets, field positions, resets.
// Assumes inclusion by the timer package and by every timer design file.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define TMR_CNT_W 16
`define TMR_PRE_W 8
`define TMR_DIV_W 4
`define TMR_CTL_W 16
`define TMR_CTL_OFS 4'h0
`define TMR_REF_OFS 4'h4
`define TMR_CAP_OFS 4'h8
`define TMR_CNT_OFS 4'hc
`define TMR_STAT_ADDR 8'h80
`define TMR_CLR_ADDR 8'h84
`define TMR_IEN_ADDR 8'h88
`define TMR_EN_BIT 0
`define TMR_SEL_LSB 1
`define TMR_EDGE_LSB 3
`define TMR_TOG_BIT 5
`define TMR_OE_BIT 6
`define TMR_PRE_LSB 8
`define TMR_CTL_RST 16'h0000
`define TMR_REF_RST 16'hffff
`define TMR_OUT_IDLE 1'b1
`endif

// *** timer_pkg.sv ***
// Types shared by the dual timer top and its channel.
// Assumes timer_cfg.svh is on the include path.
`include "timer_cfg.svh"
package timer_pkg;
    typedef enum logic [1:0] {CLK_DIV1, CLK_DIV16, CLK_EVENT, CLK_OFF}
        clk_sel_type;
    typedef struct packed {
        logic en;
        clk_sel_type sel;
        logic [1:0] edge_sel;
        logic toggle;
        logic out_en;
        logic [`TMR_PRE_W-1:0] presc;
        logic [`TMR_CNT_W-1:0] refv;
    } chan_ctl_type;
    typedef struct packed {
        logic tick;
        logic cap_evt;
        logic ref_evt;
    } chan_evt_type;
endpackage : timer_pkg

// *** timer_chan.sv ***
// One timer channel: prescaler, free-running counter, capture and compare.
// Assumes control comes from registers and the input is synchronous.
`include "timer_cfg.svh"
module timer_chan (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control from the register file
    input wire timer_pkg::chan_ctl_type ctl,
    input wire logic div16_tick,
    input wire logic cnt_clr,
    // Pins
    input wire logic tin,
    output logic tout_n,
    // Results
    output timer_pkg::chan_evt_type evt,
    output logic [`TMR_CNT_W-1:0] cnt,
    output logic [`TMR_CNT_W-1:0] cap
);
    typedef struct packed {
        logic [`TMR_PRE_W-1:0] presc;
        logic [`TMR_CNT_W-1:0] cnt;
        logic [`TMR_CNT_W-1:0] cap;
        logic tin_prev;
        logic tout_n;
    } chan_state_type;

    chan_state_type q;
    chan_state_type d;
    logic rise;
    logic fall;
    logic edge_hit;
    logic src;
    logic [`TMR_CNT_W-1:0] cnt_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d = q;
        evt = '0;
        rise = tin & ~q.tin_prev;
        fall = ~tin & q.tin_prev;
        edge_hit = (ctl.edge_sel[0] & rise) | (ctl.edge_sel[1] & fall);
        src = (ctl.sel == timer_pkg::CLK_DIV1) ||
            ((ctl.sel == timer_pkg::CLK_DIV16) && div16_tick);
        cnt_next = q.cnt + `TMR_CNT_W'(1);
        d.tin_prev = tin;
        if (!ctl.en)
        begin
            d.presc = '0;
        end
        else if (ctl.sel == timer_pkg::CLK_EVENT)
        begin
            evt.tick = edge_hit;
        end
        else if (src)
        begin
            if (q.presc == ctl.presc)
            begin
                evt.tick = 1'b1;
                d.presc = '0;
            end
            else
            begin
                d.presc = q.presc + `TMR_PRE_W'(1);
            end
        end
        // The count wraps through zero; the enable or the CLK_OFF source stops it.
        if (evt.tick)
        begin
            d.cnt = cnt_next;
        end
        evt.ref_evt = evt.tick && (cnt_next == ctl.refv);
        evt.cap_evt = ctl.en && edge_hit && (ctl.sel != timer_pkg::CLK_EVENT);
        if (evt.cap_evt)
        begin
            d.cap = q.cnt;
        end
        if (evt.ref_evt && ctl.out_en)
        begin
            d.tout_n = ctl.toggle ? ~q.tout_n : 1'b0;
        end
        else if (!ctl.toggle)
        begin
            d.tout_n = `TMR_OUT_IDLE;
        end
        if (cnt_clr)
        begin
            d.cnt = '0;
            d.presc = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q <= '{tout_n: `TMR_OUT_IDLE, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    assign cnt = q.cnt;
    assign cap = q.cap;
    assign tout_n = q.tout_n;
endmodule : timer_chan

// *** timer_top.sv ***
// Dual general-purpose timer with an APB register file and one interrupt.
// Assumes a 20 MHz bus clock and timer inputs synchronous to it.
//
// The APB slave port and the register addresses were left to the implementer.
`include "timer_cfg.svh"
module timer_top #(
    parameter int NCH = 2
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Timer pins
    input wire logic [NCH-1:0] TIN,
    output logic [NCH-1:0] TOUT_N,
    // Interrupt
    output logic IRQ
);
    // Eight channels fill the low half of the map; more would hit status.
    initial
    begin
        if (NCH < 1 || NCH > 8)
        begin
            $error("NCH must lie between 1 and 8.");
        end
    end

    typedef struct packed {
        logic [NCH-1:0][`TMR_CTL_W-1:0] ctl;
        logic [NCH-1:0][`TMR_CNT_W-1:0] refv;
        logic [2*NCH-1:0] stat;
        logic [2*NCH-1:0] ien;
        logic irq;
        logic [`TMR_DIV_W-1:0] div;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } state_type;

    localparam state_type RST = '{
        ctl: {NCH{`TMR_CTL_RST}},
        refv: {NCH{`TMR_REF_RST}},
        default: '0
    };

    state_type q;
    state_type d;
    timer_pkg::chan_ctl_type [NCH-1:0] ctl;
    timer_pkg::chan_evt_type [NCH-1:0] evt;
    logic [NCH-1:0][`TMR_CNT_W-1:0] cnt;
    logic [NCH-1:0][`TMR_CNT_W-1:0] cap;
    logic [NCH-1:0] cnt_clr;
    logic [2*NCH-1:0] set;
    logic div16_tick;
    logic setup;
    logic acc_wr;
    logic chan_hit;
    logic [2:0] idx;
    logic [3:0] ofs;

    ////////////////////////////////////////////////////////////////////////
    // Field decode and channels.
    assign div16_tick = &q.div;
    assign idx = PADDR[6:4];
    assign ofs = PADDR[3:0];
    assign chan_hit = !PADDR[7] && (32'(idx) < NCH);
    assign acc_wr = PSEL && PENABLE && q.ready && PWRITE;

    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        assign ctl[i].en = q.ctl[i][`TMR_EN_BIT];
        assign ctl[i].sel = timer_pkg::clk_sel_type'(
            q.ctl[i][`TMR_SEL_LSB +: 2]);
        assign ctl[i].edge_sel = q.ctl[i][`TMR_EDGE_LSB +: 2];
        assign ctl[i].toggle = q.ctl[i][`TMR_TOG_BIT];
        assign ctl[i].out_en = q.ctl[i][`TMR_OE_BIT];
        assign ctl[i].presc = q.ctl[i][`TMR_PRE_LSB +: `TMR_PRE_W];
        assign ctl[i].refv = q.refv[i];
        assign cnt_clr[i] = acc_wr && chan_hit && (32'(idx) == i) &&
            (ofs == `TMR_CNT_OFS);
        assign set[2*i] = evt[i].cap_evt;
        assign set[2*i+1] = evt[i].ref_evt;

        timer_chan u_chan (
            .clk(CLK),
            .arst_n(ARST_N),
            .ctl(ctl[i]),
            .div16_tick(div16_tick),
            .cnt_clr(cnt_clr[i]),
            .tin(TIN[i]),
            .tout_n(TOUT_N[i]),
            .evt(evt[i]),
            .cnt(cnt[i]),
            .cap(cap[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and interrupt.
    always_comb
    begin
        d = q;
        setup = PSEL && !PENABLE;
        d.div = q.div + `TMR_DIV_W'(1);
        d.ready = setup;
        d.slverr = 1'b0;
        // Read data is fetched in setup so that PRDATA leaves a flop.
        if (setup)
        begin
            d.rdata = '0;
            if (chan_hit && ofs == `TMR_CTL_OFS)
            begin
                d.rdata = 32'(q.ctl[idx]);
            end
            else if (chan_hit && ofs == `TMR_REF_OFS)
            begin
                d.rdata = 32'(q.refv[idx]);
            end
            else if (chan_hit && ofs == `TMR_CAP_OFS)
            begin
                d.rdata = 32'(cap[idx]);
            end
            else if (chan_hit && ofs == `TMR_CNT_OFS)
            begin
                d.rdata = 32'(cnt[idx]);
            end
            else if (PADDR == `TMR_STAT_ADDR)
            begin
                d.rdata = 32'(q.stat);
            end
            else if (PADDR == `TMR_IEN_ADDR)
            begin
                d.rdata = 32'(q.ien);
            end
            else if (PADDR != `TMR_CLR_ADDR)
            begin
                d.slverr = 1'b1;
            end
        end
        else
        begin
            d.slverr = q.slverr && !q.ready;
        end
        d.stat = q.stat;
        if (acc_wr && !q.slverr)
        begin
            if (chan_hit && ofs == `TMR_CTL_OFS)
            begin
                d.ctl[idx] = PWDATA[`TMR_CTL_W-1:0];
            end
            else if (chan_hit && ofs == `TMR_REF_OFS)
            begin
                d.refv[idx] = PWDATA[`TMR_CNT_W-1:0];
            end
            else if (PADDR == `TMR_CLR_ADDR)
            begin
                d.stat = q.stat & ~PWDATA[2*NCH-1:0];
            end
            else if (PADDR == `TMR_IEN_ADDR)
            begin
                d.ien = PWDATA[2*NCH-1:0];
            end
        end
        // A new event in the clearing cycle survives the clear.
        d.stat = d.stat | set;
        d.irq = |(d.stat & d.ien);
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            q <= RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign PRDATA = q.rdata;
    assign PREADY = q.ready;
    assign PSLVERR = q.slverr;
    assign IRQ = q.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    // Every check runs on the bus clock and is muted while reset is low.
    // The timer has one clock, so one default clocking serves them all.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    AST_DIV16_PERIOD: assert property (
        div16_tick |-> ##16 div16_tick)
        else $error("Divide-by-16 enable lost its period.");

    AST_APB_ANSWER: assert property (
        (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
        else $error("APB answer not one access cycle.");

    AST_IRQ_LEVEL: assert property (
        ##1 (IRQ == |(q.stat & q.ien)))
        else $error("Interrupt does not follow enabled status.");

    AST_ERR_WITH_READY: assert property (
        PSLVERR |-> PREADY)
        else $error("Bus error shown outside an access.");

    AST_ERR_IGNORED: assert property (
        PSEL && PENABLE && PREADY && PSLVERR |=>
        $stable(q.ctl) && $stable(q.refv) && $stable(q.ien))
        else $error("Refused write changed a register.");

    AST_IEN_WRITE: assert property (
        acc_wr && PADDR == `TMR_IEN_ADDR |=>
        q.ien == $past(PWDATA[2*NCH-1:0]))
        else $error("Enable write did not land.");

    // Set wins over clear so that no event is lost to a late clear.
    for (genvar j = 0; j < 2*NCH; j++)
    begin : g_stat_chk
        AST_STAT_SET: assert property (
            set[j] |=> q.stat[j])
            else $error("Status bit missed its event.");

        AST_STAT_STICKY: assert property (
            q.stat[j] && !(acc_wr && PADDR == `TMR_CLR_ADDR &&
            PWDATA[j]) |=> q.stat[j])
            else $error("Status bit fell without a clear.");

        AST_STAT_CLEAR: assert property (
            acc_wr && PADDR == `TMR_CLR_ADDR && PWDATA[j] && !set[j]
            |=> !q.stat[j])
            else $error("Status clear did not take effect.");
    end

    for (genvar i = 0; i < NCH; i++)
    begin : g_chk
        // A count write restarts the prescaler, so the gap check waits.
        sequence s_hold4;
            ($stable(ctl[i]) && !cnt_clr[i])[*4];
        endsequence
        sequence s_pulse;
            !TOUT_N[i] ##1 TOUT_N[i];
        endsequence

        AST_COUNT_STEP: assert property (
            evt[i].tick && !cnt_clr[i] |=>
            cnt[i] == $past(cnt[i]) + `TMR_CNT_W'(1))
            else $error("Counter did not step on a tick.");

        AST_WRAP: assert property (
            evt[i].tick && !cnt_clr[i] && (&cnt[i]) |=> cnt[i] == '0)
            else $error("Counter did not wrap to zero.");

        AST_HALT: assert property (
            !ctl[i].en && !cnt_clr[i] |=> $stable(cnt[i]))
            else $error("Disabled counter moved.");

        AST_CAPTURE: assert property (
            evt[i].cap_evt |=> cap[i] == $past(cnt[i]) &&
            q.stat[2*i])
            else $error("Capture value or flag wrong.");

        AST_EVENT_COUNT: assert property (
            ctl[i].en && ctl[i].sel == timer_pkg::CLK_EVENT &&
            ctl[i].edge_sel[0] && !TIN[i] ##1 TIN[i] &&
            $stable(ctl[i]) |-> evt[i].tick)
            else $error("Rising input edge not counted.");

        AST_PRESCALE3: assert property (
            evt[i].tick && ctl[i].en && ctl[i].presc == 8'h03 &&
            ctl[i].sel == timer_pkg::CLK_DIV1 ##1 s_hold4 |->
            evt[i].tick && !$past(evt[i].tick) &&
            !$past(evt[i].tick, 2) && !$past(evt[i].tick, 3))
            else $error("Prescaler of four gave a wrong gap.");

        AST_REF_FLAG: assert property (
            evt[i].ref_evt && !cnt_clr[i] |=>
            q.stat[2*i+1] && cnt[i] == ctl[i].refv)
            else $error("Compare match not flagged.");

        AST_PULSE: assert property (
            evt[i].ref_evt && ctl[i].out_en && !ctl[i].toggle ##1
            !ctl[i].toggle |-> s_pulse)
            else $error("Compare pulse not one cycle low.");

        AST_TOGGLE: assert property (
            evt[i].ref_evt && ctl[i].out_en && ctl[i].toggle |=>
            TOUT_N[i] != $past(TOUT_N[i]))
            else $error("Compare did not toggle the output.");

        AST_CTL_WRITE: assert property (
            acc_wr && chan_hit && 32'(idx) == i && !PSLVERR &&
            ofs == `TMR_CTL_OFS |=>
            q.ctl[i] == $past(PWDATA[`TMR_CTL_W-1:0]))
            else $error("Control write did not land.");

        AST_REF_WRITE: assert property (
            acc_wr && chan_hit && 32'(idx) == i && !PSLVERR &&
            ofs == `TMR_REF_OFS |=>
            ctl[i].refv == $past(PWDATA[`TMR_CNT_W-1:0]))
            else $error("Reference write did not land.");

        AST_CNT_CLEAR: assert property (
            cnt_clr[i] |=> cnt[i] == '0)
            else $error("Count write did not clear the counter.");

        AST_CAP_HOLD: assert property (
            !evt[i].cap_evt |=> $stable(cap[i]))
            else $error("Capture register moved without an event.");

        AST_NO_CAP_EVENT: assert property (
            ctl[i].sel == timer_pkg::CLK_EVENT |-> !evt[i].cap_evt)
            else $error("Capture fired in event mode.");

        AST_OFF_STILL: assert property (
            ctl[i].sel == timer_pkg::CLK_OFF |-> !evt[i].tick)
            else $error("Stopped clock source still ticked.");

        AST_IDLE_STILL: assert property (
            !ctl[i].en |-> !evt[i].tick && !evt[i].cap_evt)
            else $error("Disabled channel produced an event.");

        AST_PULSE_IDLE: assert property (
            !ctl[i].toggle && !(evt[i].ref_evt && ctl[i].out_en) |=>
            TOUT_N[i])
            else $error("Pulse mode output not back at idle.");
    end
endmodule : timer_top

// *** event_src.sv ***
// Model of the far side: event source on the timer inputs.
// Assumes the bench commands it one burst of edges at a time.
module event_src (
    // Clock
    input wire logic clk,
    // Command
    input wire logic start,
    input wire logic pin,
    input wire logic [7:0] count,
    // Pins and busy flag
    output logic [1:0] tin,
    output logic busy
);
    logic [7:0] left;
    logic ph;
    logic p;
    initial
    begin
        tin = 2'h0;
        busy = 1'b0;
    end
    ////////////////////////////////////////
    // Edges two cycles apart, so none is missed by the sampler.
    always @(posedge clk)
    begin
        if (!busy && start)
        begin
            busy <= (count != 8'h00);
            left <= count;
            p <= pin;
            ph <= 1'b0;
        end
        else if (busy)
        begin
            ph <= ~ph;
            if (!ph)
            begin
                tin[p] <= ~tin[p];
                left <= left - 8'h01;
                busy <= (left != 8'h01);
            end
        end
    end
endmodule : event_src

// *** tb.sv ***
// Self-checking bench of the dual timer over its register bus.
// Assumes the default of two channels and a 20 MHz clock.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, IRQ, busy, err;
    logic [1:0] TIN, TOUT_N;
    logic st = 1'b0;
    logic pin = 1'b0;
    logic [7:0] cnt_n = 8'h00;
    logic [31:0] rv, a, b, cp;
    logic [15:0] ctls [3] = '{16'h0001, 16'h0301, 16'h0103};
    int divs [3] = '{1, 4, 32};
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int n, d;
    time t0;
    timer_top dut_u (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .TIN(TIN), .TOUT_N(TOUT_N), .IRQ(IRQ));
    event_src partner_u (.clk(CLK), .start(st), .pin(pin),
        .count(cnt_n), .tin(TIN), .busy(busy));
    always #25 CLK = ~CLK;
    // The wrap test alone needs some 66000 cycles.
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            fails++;
            end_of_test();
        end
    end
    ////////////////////////////////////////
    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] s,
        input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] ad,
        input logic [31:0] dt);
        int k;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= dt;
        @(posedge CLK);
        PENABLE <= 1'b1;
        k = 0;
        do
        begin
            @(posedge CLK);
            k++;
        end
        while (PREADY !== 1'b1 && k < 20);
        rv = PRDATA;
        err = PSLVERR;
        if (k == 20)
        begin
            fails++;
            end_of_test();
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        xfer(1'b1, ad, dt);
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] ad,
        input logic [31:0] e);
        xfer(1'b0, ad, 32'h0);
        chk(nm, rv, e);
    endtask : rd
    task automatic tg(input logic p, input logic [7:0] k);
        int m;
        @(posedge CLK);
        pin <= p;
        cnt_n <= k;
        st <= 1'b1;
        @(posedge CLK);
        st <= 1'b0;
        // Busy rises only at the edge that takes the start.
        @(posedge CLK);
        m = 0;
        do
        begin
            @(posedge CLK);
            m++;
        end
        while (busy && m < 100);
        if (m == 100)
        begin
            fails++;
            end_of_test();
        end
        repeat (3) @(posedge CLK);
    endtask : tg
    ////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge CLK);
        ARST_N <= 1'b1;
        rd("ctl0", 8'h00, 32'h0);
        rd("ref0", 8'h04, 32'h0000ffff);
        chk("tout", {30'h0, TOUT_N}, 32'h3);
        rd("unmapped", 8'h40, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h00, {16'h0, ctls[i]});
            wr(8'h0c, 32'h0);
            xfer(1'b0, 8'h0c, 32'h0);
            a = rv;
            t0 = $time;
            repeat (200) @(posedge CLK);
            xfer(1'b0, 8'h0c, 32'h0);
            b = rv;
            d = int'(($time - t0) / 50) / divs[i];
            chk("rate", {31'h0, (b - a == d) || (divs[i] > 1
                && b - a == d + 1)}, 32'h1);
        end
        wr(8'h00, 32'h0);
        wr(8'h88, 32'h2);
        wr(8'h84, 32'hff);
        wr(8'h04, 32'd20);
        wr(8'h00, 32'h41);
        wr(8'h0c, 32'h0);
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (TOUT_N[0] !== 1'b0 && n < 40);
        chk("match", {31'h0, n >= 18 && n <= 22}, 32'h1);
        @(posedge CLK);
        chk("pulse", {31'h0, TOUT_N[0]}, 32'h1);
        chk("irq", {31'h0, IRQ}, 32'h1);
        rd("stat", 8'h80, 32'h2);
        wr(8'h88, 32'h0);
        repeat (2) @(posedge CLK);
        chk("masked", {31'h0, IRQ}, 32'h0);
        wr(8'h88, 32'h2);
        wr(8'h84, 32'h2);
        repeat (2) @(posedge CLK);
        chk("cleared", {31'h0, IRQ}, 32'h0);
        rd("stat", 8'h80, 32'h0);
        wr(8'h04, 32'd10);
        a = {31'h0, TOUT_N[0]};
        wr(8'h00, 32'h61);
        wr(8'h0c, 32'h0);
        repeat (30) @(posedge CLK);
        chk("toggle", {31'h0, TOUT_N[0]}, a ^ 32'h1);
        wr(8'h00, 32'h0);
        wr(8'h84, 32'hff);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h0c, 32'h0);
        repeat (65600) @(posedge CLK);
        rd("wrap", 8'h80, 32'h2);
        xfer(1'b0, 8'h0c, 32'h0);
        chk("after", {31'h0, rv < 32'd200}, 32'h1);
        wr(8'h00, 32'h0);
        wr(8'h84, 32'hff);
        wr(8'h10, 32'h09);
        wr(8'h1c, 32'h0);
        xfer(1'b0, 8'h1c, 32'h0);
        a = rv;
        tg(1'b1, 8'd1);
        xfer(1'b0, 8'h18, 32'h0);
        cp = rv;
        xfer(1'b0, 8'h1c, 32'h0);
        b = rv;
        chk("cap", {31'h0, a < cp && cp < b}, 32'h1);
        rd("stat", 8'h80, 32'h4);
        tg(1'b1, 8'd1);
        rd("cap2", 8'h18, cp);
        wr(8'h10, 32'h1d);
        wr(8'h1c, 32'h0);
        tg(1'b1, 8'd10);
        rd("events", 8'h1c, 32'd10);
        repeat (20) @(posedge CLK);
        rd("events", 8'h1c, 32'd10);
        end_of_test();
    end
endmodule : tb
